// ==== common/i2c_cond_pkg.sv ====
// Constants and types for the bus-condition control block
package i2c_cond_pkg;

   // Register byte addresses (word aligned)
   localparam logic [3:0] ADDR_COND_CTRL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK  = 4'h8;
   localparam logic [3:0] ADDR_MODE      = 4'hC;

   // Control register bit positions
   localparam int BIT_BUSY    = 7;
   localparam int BIT_INHIBIT = 6;
   localparam int BIT_SDA_MON = 5;
   localparam int BIT_RSVD4   = 4;
   localparam int BIT_SCL_MON = 3;
   localparam int BIT_RSVD2   = 2;

   // Status / mask bit positions
   localparam int IRQ_START_SEEN = 0;
   localparam int IRQ_STOP_SEEN  = 1;
   localparam int IRQ_CMD_DONE   = 2;
   localparam int IRQ_W          = 3;

   // Mode register bit
   localparam int BIT_MASTER = 0;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // Condition timing: half of a 100 kHz bus period
   localparam int HALF_PERIOD_NS = 5000;
   localparam int CLK_PERIOD_NS  = 5;
   localparam int HALF_CYC       = HALF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CNT_W          = 10;
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START_SETUP,
      ST_START_LOW,
      ST_STOP_SDA_LOW,
      ST_STOP_SCL_HIGH,
      ST_STOP_RELEASE
   } cond_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_pair_t;

endpackage

// ==== rtl/i2c_bus_condition_control.sv ====
// Start/stop generation, bus-occupancy tracking and drive monitor for I2C
// Line levels are synchronised and debounced before edge detection.
// Commands drive an open-drain sequencer paced in half bus periods.
// Busy reflects what the bus shows, so other masters count too.
module i2c_bus_condition_control
   import i2c_cond_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   output logic             sda_o,
   output logic             sda_oe_o
);

   // Three-stage line samplers; stage 0 only feeds stage 1
   line_pair_t       s0_q;
   line_pair_t       s1_q;
   line_pair_t       s2_q;
   line_pair_t       prev_q;
   logic             busy_q;
   logic             master_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   cond_state_t      st_q;
   logic [CNT_W-1:0] cnt_q;
   logic             drv_sda_q;
   logic             drv_scl_q;
   logic             cmd_done;

   // One address decode shared by every register write
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [3:0] addr,
                                    input logic [3:0] target);
      return strobe && (addr == target);
   endfunction

   // Byte registers sit in the low lane of a zero word
   function automatic logic [31:0] to_word(input logic [7:0] b);
      return {24'h00_0000, b};
   endfunction

   wire logic req     = cyc_i && stb_i && !ack_o;
   wire logic wr_lane = req && we_i && sel_i[0];
   wire logic ctrl_wr = reg_hit(wr_lane, adr_i, ADDR_COND_CTRL);
   wire logic stat_wr = reg_hit(wr_lane, adr_i, ADDR_IRQ_STAT);
   wire logic mask_wr = reg_hit(wr_lane, adr_i, ADDR_IRQ_MASK);
   wire logic mode_wr = reg_hit(wr_lane, adr_i, ADDR_MODE);
   wire logic cond_ok = ctrl_wr && master_q && !dat_i[BIT_INHIBIT] && st_q == ST_IDLE;
   wire logic do_start = cond_ok && dat_i[BIT_BUSY];
   wire logic do_stop  = cond_ok && !dat_i[BIT_BUSY];

   function automatic logic settled(input logic a, input logic b);
      return a == b;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s0_q   <= '{scl: 1'b1, sda: 1'b1};
         s1_q   <= '{scl: 1'b1, sda: 1'b1};
         s2_q   <= '{scl: 1'b1, sda: 1'b1};
         prev_q <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         s0_q <= '{scl: scl_i, sda: sda_i};
         s1_q <= s0_q;
         s2_q <= s1_q;
         if (settled(s1_q.scl, s2_q.scl)) begin
            prev_q.scl <= s2_q.scl;
         end
         if (settled(s1_q.sda, s2_q.sda)) begin
            prev_q.sda <= s2_q.sda;
         end
      end
   end

   // Agreed new levels of the lines; a one-sample glitch never counts,
   // at the price of three cycles of latency on every edge
   wire logic sda_new  = settled(s1_q.sda, s2_q.sda) ? s2_q.sda : prev_q.sda;
   wire logic scl_high = prev_q.scl && settled(s1_q.scl, s2_q.scl) && s2_q.scl;
   wire logic start_seen = scl_high && prev_q.sda && !sda_new;
   wire logic stop_seen  = scl_high && !prev_q.sda && sda_new;

   // Occupancy follows the observed bus, not the command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
      end else if (start_seen) begin
         busy_q <= 1'b1;
      end else if (stop_seen) begin
         busy_q <= 1'b0;
      end
   end

   // Conditions are only issued once software has chosen master mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_q <= 1'b0;
      end else if (mode_wr) begin
         master_q <= dat_i[BIT_MASTER];
      end
   end

   // Condition sequencer; a repeated start first releases SDA with SCL low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q      <= ST_IDLE;
         cnt_q     <= CNT_ZERO;
         drv_sda_q <= 1'b1;
         drv_scl_q <= 1'b1;
      end else if (cnt_q != CNT_ZERO) begin
         cnt_q <= cnt_q - 1'b1;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (do_start) begin
                  drv_sda_q <= 1'b1;
                  st_q      <= ST_START_SETUP;
                  cnt_q     <= HALF_CNT;
               end else if (do_stop) begin
                  drv_sda_q <= 1'b0;
                  st_q      <= ST_STOP_SDA_LOW;
                  cnt_q     <= HALF_CNT;
               end
            end
            // SCL is released first; SDA falls only once SCL is high
            ST_START_SETUP: begin
               drv_scl_q <= 1'b1;
               if (drv_scl_q) begin
                  drv_sda_q <= 1'b0;
                  st_q      <= ST_START_LOW;
               end
               cnt_q <= HALF_CNT;
            end
            // Hold SCL low so the first data bit may be set up
            ST_START_LOW: begin
               drv_scl_q <= 1'b0;
               st_q      <= ST_IDLE;
               cnt_q     <= HALF_CNT;
            end
            // SDA already low; release SCL before SDA
            ST_STOP_SDA_LOW: begin
               drv_scl_q <= 1'b1;
               st_q      <= ST_STOP_SCL_HIGH;
               cnt_q     <= HALF_CNT;
            end
            ST_STOP_SCL_HIGH: begin
               drv_sda_q <= 1'b1;
               st_q      <= ST_STOP_RELEASE;
               cnt_q     <= HALF_CNT;
            end
            // Bus free time before another command
            ST_STOP_RELEASE: begin
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // One-cycle event at the last half period of each command
   assign cmd_done = (cnt_q == CNT_ZERO)
                     && (st_q == ST_START_LOW || st_q == ST_STOP_RELEASE);

   // Open-drain: only a low is driven, a high is released
   // Registered so the pins never see decode glitches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sda_o    <= 1'b0;
         scl_o    <= 1'b0;
         sda_oe_o <= 1'b0;
         scl_oe_o <= 1'b0;
      end else begin
         sda_o    <= 1'b0;
         scl_o    <= 1'b0;
         sda_oe_o <= !drv_sda_q;
         scl_oe_o <= !drv_scl_q;
      end
   end

   // Sticky events; a new event wins over a write-one clear
   logic [IRQ_W-1:0] ev;
   always_comb begin
      ev = '0;
      ev[IRQ_START_SEEN] = start_seen;
      ev[IRQ_STOP_SEEN]  = stop_seen;
      ev[IRQ_CMD_DONE]   = cmd_done;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= '0;
      end else begin
         if (stat_wr) begin
            stat_q <= (stat_q & ~dat_i[IRQ_W-1:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= '0;
      end else if (mask_wr) begin
         mask_q <= dat_i[IRQ_W-1:0];
      end
   end

   // Level output, one cycle behind the status bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q & mask_q);
      end
   end

   // Control byte image; the stored busy value comes only from the bus
   logic [7:0] ctrl_rd;
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[BIT_BUSY]    = busy_q;
      ctrl_rd[BIT_INHIBIT] = 1'b1;
      ctrl_rd[BIT_SDA_MON] = drv_sda_q;
      ctrl_rd[BIT_RSVD4]   = 1'b1;
      ctrl_rd[BIT_SCL_MON] = drv_scl_q;
      ctrl_rd[BIT_RSVD2]   = 1'b1;
   end

   // Wishbone slave: one registered answer per request, one cycle after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // Read data stands only in the ack cycle; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= RD_ZERO;
      end else if (req && !we_i) begin
         unique case (adr_i)
            ADDR_COND_CTRL: dat_o <= to_word(ctrl_rd);
            ADDR_IRQ_STAT:  dat_o <= to_word(8'(stat_q));
            ADDR_IRQ_MASK:  dat_o <= to_word(8'(mask_q));
            ADDR_MODE:      dat_o <= to_word(8'(master_q));
            default:        dat_o <= RD_ZERO;
         endcase
      end else begin
         dat_o <= RD_ZERO;
      end
   end

endmodule // i2c_bus_condition_control

// ==== testbench/i2c_cond_asserts.sv ====
// Port assertions for the bus-condition control block
module i2c_cond_asserts
   import i2c_cond_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [3:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd_ctrl = ack_o && !we_i && adr_i == ADDR_COND_CTRL;
   // Half-period gaps are too long for a delay range, so count them
   logic [CNT_W:0] start_gap_q;
   logic [CNT_W:0] stop_gap_q;
   logic           start_arm_q;
   logic           stop_arm_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_arm_q <= 1'b0;
         start_gap_q <= '0;
      end else if ($rose(sda_oe_o) && !scl_oe_o) begin
         start_arm_q <= 1'b1;
         start_gap_q <= 11'h001;
      end else if ($rose(scl_oe_o)) begin
         start_arm_q <= 1'b0;
      end else if (start_arm_q) begin
         start_gap_q <= start_gap_q + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_arm_q <= 1'b0;
         stop_gap_q <= '0;
      end else if ($fell(scl_oe_o) && sda_oe_o) begin
         stop_arm_q <= 1'b1;
         stop_gap_q <= 11'h001;
      end else if ($fell(sda_oe_o)) begin
         stop_arm_q <= 1'b0;
      end else if (stop_arm_q) begin
         stop_gap_q <= stop_gap_q + 1'b1;
      end
   end
   sequence start_release;
      start_arm_q && $rose(scl_oe_o);
   endsequence
   sequence stop_finish;
      stop_arm_q && $fell(sda_oe_o);
   endsequence
   chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack");
   chk_rdata_idle: assert property (!ack_o |-> dat_o == RD_ZERO) else $error("stray data");
   chk_inhibit_reads: assert property (rd_ctrl |-> dat_o[BIT_INHIBIT] && dat_o[BIT_RSVD2])
      else $error("inhibit read");
   chk_sda_monitor: assert property (rd_ctrl && $stable(sda_oe_o) |->
      dat_o[BIT_SDA_MON] == !sda_oe_o) else $error("sda monitor");
   chk_scl_monitor: assert property (rd_ctrl && $stable(scl_oe_o) |->
      dat_o[BIT_SCL_MON] == !scl_oe_o) else $error("scl monitor");
   // Start: SCL must follow SDA low after one half period
   chk_start_order: assert property (start_release |-> start_gap_q == HALF_CYC)
      else $error("start order");
   chk_start_bound: assert property (start_arm_q |-> start_gap_q <= HALF_CYC)
      else $error("start too slow");
   chk_stop_order: assert property (stop_finish |-> stop_gap_q == HALF_CYC)
      else $error("stop order");
   chk_stop_bound: assert property (stop_arm_q |-> stop_gap_q <= HALF_CYC)
      else $error("stop too slow");
endmodule // i2c_cond_asserts

// ==== testbench/i2c_peer.sv ====
// Another device on the two-wire bus, pull-ups on both lines
module i2c_peer (
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   // Released lines float high, never hold a stale level
   assign scl_o = !(scl_oe_i || scl_low);
   assign sda_o = !(sda_oe_i || sda_low);
   // Own start, then link clock at 160 ns; clock idles outside frames
   task automatic start_frame();
      sda_low = 1'b1;
      #80;
      repeat (8) begin
         scl_low = 1'b1;
         #80;
         scl_low = 1'b0;
         #80;
      end
   endtask
   task automatic stop_frame();
      sda_low = 1'b0;
   endtask
endmodule // i2c_peer

// ==== testbench/tb_i2c_bus_condition_control.sv ====
// Self-checking bench for the bus-condition control block
module tb_i2c_bus_condition_control;
   import i2c_cond_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic        scl_o, sda_o;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic        ack_o, irq_o, scl_i, sda_i, scl_oe_o, sda_oe_o;
   logic [7:0]  rd;
   int          fail_count = 0;
   int          samples_checked = 0;
   always #2.5 clk_i = ~clk_i;
   i2c_bus_condition_control i2c_bus_condition_control_i (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .scl_i, .sda_i,
      .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
   i2c_peer i2c_peer_i (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h00_0000, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Not yet master: condition writes are ignored
   task automatic t_idle();
      wb(1'b1, ADDR_COND_CTRL, 8'h00);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'h7C);
      wb(1'b0, 4'h2, 8'h00);
      chk(rd, 8'h00);
   endtask
   task automatic t_peer();
      wb(1'b1, ADDR_IRQ_MASK, 8'h01);
      i2c_peer_i.start_frame();
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'hFC);
      chk({7'h00, irq_o}, 8'h01);
      wb(1'b1, ADDR_IRQ_STAT, 8'h01);
      repeat (2) @(negedge clk_i);
      chk({7'h00, irq_o}, 8'h00);
      i2c_peer_i.stop_frame();
      repeat (8) @(posedge clk_i);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'h7C);
   endtask
   task automatic t_inhibit();
      wb(1'b1, ADDR_MODE, 8'h01);
      wb(1'b1, ADDR_COND_CTRL, 8'hC0);
      wb(1'b1, ADDR_COND_CTRL, 8'h40);
      repeat (50) @(posedge clk_i);
      chk({6'h00, sda_oe_o, scl_oe_o}, 8'h00);
      chk({6'h00, sda_o, scl_o}, 8'h00);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'h7C);
   endtask
   // Start, repeated start, stop; waits cover every half period
   task automatic t_cond();
      wb(1'b1, ADDR_COND_CTRL, 8'h80);
      repeat (3100) @(posedge clk_i);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'hD4);
      wb(1'b1, ADDR_COND_CTRL, 8'h80);
      repeat (4100) @(posedge clk_i);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'hD4);
      wb(1'b1, ADDR_COND_CTRL, 8'h00);
      repeat (3100) @(posedge clk_i);
      wb(1'b0, ADDR_COND_CTRL, 8'h00);
      chk(rd, 8'h7C);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_idle();
      t_peer();
      t_inhibit();
      t_cond();
      end_sim();
   end
   initial begin
      #100_000;
      fail_count++;
      end_sim();
   end
endmodule // tb_i2c_bus_condition_control
bind i2c_bus_condition_control i2c_cond_asserts i2c_cond_asserts_i (.clk_i, .rst_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .scl_oe_o, .sda_oe_o);
